// file: src/sdr_pkg.sv
/*
 * Shared constants and types for the receiver digital core.
 * Assumes a single 20 MHz system clock with synchronous active-high reset.
 */
package sdr_pkg;
    // System clock and sample timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned ADC_RATE_HZ = 32_068;
    localparam int unsigned ADC_PERIOD_CYC = CLK_HZ / ADC_RATE_HZ;
    localparam int ADC_CNT_W = 10;

    // Synthesizer figures; reference and loop range belong to the analog PLL
    localparam int unsigned REF_HZ = 24_000_000;
    localparam int unsigned PLL_MIN_HZ = 56_000_000;
    localparam int unsigned PLL_MAX_HZ = 68_000_000;
    localparam int unsigned TUNE_STEP_HZ = 50;
    localparam int MASH_W = 14;
    localparam int NINT_W = 8;
    localparam int LODIV_W = 8;

    // Datapath widths
    localparam int ADC_W = 14;
    localparam int DATA_W = 24;
    localparam int ACC_W = 48;
    localparam int TAPS = 64;
    localparam int TAP_W = 6;
    localparam int DLY_LEN = 32;
    localparam int DAC_W = 8;
    localparam int COEF_FRAC = 23;
    localparam int ADC_SHIFT = DATA_W - ADC_W;
    localparam logic [TAP_W-1:0] LAST_TAP = 6'h3f;

    // Coefficient bank select
    localparam logic COEF_HILBERT = 1'b0;
    localparam logic COEF_LOWPASS = 1'b1;

    // Local oscillator quarter phases
    localparam logic [1:0] LO_PH_LAST = 2'h3;

    typedef enum logic [2:0] {ST_IDLE, ST_HIL, ST_COMB, ST_LPF, ST_OUT} core_state_type;
endpackage : sdr_pkg

// file: src/tune_if.sv
/*
 * Tuning carrier between the core and its synthesizer and LO divider.
 * Assumes all signals live in the single system clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
interface tune_if;
    logic [sdr_pkg::NINT_W-1:0] n_int;
    logic [sdr_pkg::MASH_W-1:0] n_frac;
    logic fb_tick;
    logic [sdr_pkg::NINT_W-1:0] div_value;
    logic [sdr_pkg::LODIV_W-1:0] lo_div;
    logic lo_i;
    logic lo_q;
    modport core (output n_int, n_frac, fb_tick, lo_div, input div_value, lo_i, lo_q);
    modport synth (input n_int, n_frac, fb_tick, output div_value);
    modport lo (input lo_div, output lo_i, lo_q);
endinterface : tune_if
`default_nettype wire

// file: src/mash_modulator.sv
/*
 * Second-order MASH 1-1 sigma-delta modulator steering the PLL feedback divider.
 * Assumes fb_tick pulses once per feedback-divider cycle.
 */
`timescale 1ns/100ps
`default_nettype none
module mash_modulator (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Tuning carrier
    tune_if.synth tif
);
    typedef struct packed {
        logic [sdr_pkg::MASH_W-1:0] acc1;
        logic [sdr_pkg::MASH_W-1:0] acc2;
        logic c2_prev;
        logic [sdr_pkg::NINT_W-1:0] div;
    } mash_type;

    mash_type st_q, st_d;
    logic [sdr_pkg::MASH_W:0] sum1, sum2;

    always_comb begin
        st_d = st_q;
        sum1 = {1'b0, st_q.acc1} + {1'b0, tif.n_frac};
        sum2 = {1'b0, st_q.acc2} + {1'b0, sum1[sdr_pkg::MASH_W-1:0]};
        // Words are sampled only here, so a new setting never lands half-applied
        if (tif.fb_tick) begin
            st_d.acc1 = sum1[sdr_pkg::MASH_W-1:0];
            st_d.acc2 = sum2[sdr_pkg::MASH_W-1:0];
            st_d.c2_prev = sum2[sdr_pkg::MASH_W];
            // Output y = c1 + c2 - c2' swings N by -1..+2, averaging N + frac
            st_d.div = tif.n_int + sdr_pkg::NINT_W'(sum1[sdr_pkg::MASH_W])
                + sdr_pkg::NINT_W'(sum2[sdr_pkg::MASH_W])
                - sdr_pkg::NINT_W'(st_q.c2_prev);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tif.div_value = st_q.div;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_MASH_HOLD: assert property (!tif.fb_tick |=> $stable(tif.div_value))
        else $error("divider changed without a feedback tick");
    AST_MASH_SPAN: assert property (tif.fb_tick && $stable(tif.n_int)
        |=> (tif.div_value - $past(tif.n_int) + 8'h01) <= 8'h03)
        else $error("modulated divider outside N-1..N+2");
    COV_MASH_UP2: cover property (tif.fb_tick ##1 (tif.div_value == tif.n_int + 8'h02));
endmodule : mash_modulator
`default_nettype wire

// file: src/lo_divider.sv
/*
 * Programmable divider producing in-phase and quadrature detector clocks.
 * Assumes lo_div holds the quarter-period length in system clock cycles.
 */
`timescale 1ns/100ps
`default_nettype none
module lo_divider (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Tuning carrier
    tune_if.lo tif
);
    typedef struct packed {
        logic [sdr_pkg::LODIV_W-1:0] cnt;
        logic [sdr_pkg::LODIV_W-1:0] div;
        logic [1:0] ph;
        logic i;
        logic q;
    } lo_type;

    lo_type st_q, st_d;
    logic [sdr_pkg::LODIV_W-1:0] div_eff;

    always_comb begin
        st_d = st_q;
        // A zero ratio is run as one so the clocks never freeze
        div_eff = (st_q.div == '0) ? sdr_pkg::LODIV_W'(1) : st_q.div;
        st_d.cnt = st_q.cnt + sdr_pkg::LODIV_W'(1);
        if (st_q.cnt >= div_eff - sdr_pkg::LODIV_W'(1)) begin
            st_d.cnt = '0;
            st_d.ph = st_q.ph + 2'h1;
            // Ratio reloads only at a full period so duty stays square
            if (st_q.ph == sdr_pkg::LO_PH_LAST) begin
                st_d.div = tif.lo_div;
            end
        end
        // Decode the held phase so a fresh reset opens with I alone rising
        st_d.i = ~st_q.ph[1];
        st_d.q = st_q.ph[1] ^ st_q.ph[0];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tif.lo_i = st_q.i;
    assign tif.lo_q = st_q.q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_LO_I_LEADS: assert property ($rose(tif.lo_i) |-> !tif.lo_q)
        else $error("quadrature clock not lagging at I rise");
    AST_LO_Q_LAGS: assert property ($rose(tif.lo_q) |-> tif.lo_i)
        else $error("quadrature clock rose outside I high phase");
    COV_LO_CYCLE: cover property ($rose(tif.lo_i) ##[1:40] $rose(tif.lo_q));
endmodule : lo_divider
`default_nettype wire

// file: src/sdr_core.sv
/*
 * Receiver digital core: fractional-N tuning, quadrature LO, shared-ADC
 * sequencing, Hilbert sideband removal, audio low-pass and DAC feed.
 * Assumes the ADC answers each start with one adc_done pulse and that
 * firmware loads both coefficient banks and valid tuning words.
 */
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - 14-bit second-order MASH drives feedback divider
// - Dithered integer divider gives fractional average
// - About 50 Hz steps; firmware computes words
// - 24 MHz crystal is the PLL reference
// - PLL 56-68 MHz, divided to receive frequency
// - Divider makes in-phase and quadrature clocks
// - Square clocks, quadrature lags by quarter period
// - One ADC alternates between I and Q
// - 14-bit, 32,068 conversions per second total
// - One 24x24 multiply, 48-bit accumulate per cycle
// - Two independent 64-tap FIR filters
// - I into 32-sample delay, Q into FIR
// - First filter carries Hilbert coefficients
// - Add or subtract Hilbert output to I
// - I delay matches Hilbert filter latency
// - Combined stream feeds low-pass second filter
// - Each low-pass output goes to 8-bit DAC
module sdr_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Synthesizer tuning and PLL divider
    input wire logic [sdr_pkg::NINT_W-1:0] tune_int,
    input wire logic [sdr_pkg::MASH_W-1:0] tune_frac,
    input wire logic [sdr_pkg::LODIV_W-1:0] tune_lo_div,
    input wire logic pll_fb_tick,
    output logic [sdr_pkg::NINT_W-1:0] pll_div_q,
    // Detector clocks
    output logic lo_i_q,
    output logic lo_q_q,
    // Converter
    output logic adc_start_q,
    output logic adc_chan_q,
    input wire logic adc_done,
    input wire logic [sdr_pkg::ADC_W-1:0] adc_data,
    // Coefficient load
    input wire logic coef_we,
    input wire logic coef_bank,
    input wire logic [sdr_pkg::TAP_W-1:0] coef_addr,
    input wire logic [sdr_pkg::DATA_W-1:0] coef_data,
    // Audio
    input wire logic sideband_add,
    output logic [sdr_pkg::DAC_W-1:0] dac_q,
    output logic dac_strobe_q
);
    localparam int ADC_GAP = sdr_pkg::ADC_PERIOD_CYC;
    localparam int FIR_LEN = sdr_pkg::TAPS;

    typedef logic [sdr_pkg::DATA_W-1:0] word_type;

    typedef struct packed {
        sdr_pkg::core_state_type st;
        logic [sdr_pkg::ADC_CNT_W-1:0] adc_cnt;
        logic start;
        logic chan;
        logic [sdr_pkg::TAP_W-1:0] tap;
        logic signed [sdr_pkg::ACC_W-1:0] acc;
        logic sb;
        word_type hil;
        logic [sdr_pkg::DLY_LEN-1:0][sdr_pkg::DATA_W-1:0] idly;
        logic [sdr_pkg::TAPS-1:0][sdr_pkg::DATA_W-1:0] qh;
        logic [sdr_pkg::TAPS-1:0][sdr_pkg::DATA_W-1:0] sh;
        logic [sdr_pkg::TAPS-1:0][sdr_pkg::DATA_W-1:0] hc;
        logic [sdr_pkg::TAPS-1:0][sdr_pkg::DATA_W-1:0] lc;
        logic [sdr_pkg::DAC_W-1:0] dac;
        logic dstb;
    } core_type;

    core_type st_q, st_d;
    logic signed [sdr_pkg::ACC_W-1:0] prod;
    word_type sum;

    // Left-justify the converter result so the filters see full scale
    function automatic word_type to_word(input logic [sdr_pkg::ADC_W-1:0] x);
        to_word = {x, sdr_pkg::ADC_SHIFT'(0)};
    endfunction : to_word

    // Scale a Q23 accumulation back to a word, clipping instead of wrapping
    function automatic word_type sat_word(input logic signed [sdr_pkg::ACC_W-1:0] a);
        logic signed [sdr_pkg::ACC_W-1:0] s;
        s = a >>> sdr_pkg::COEF_FRAC;
        if (s > $signed({{(sdr_pkg::ACC_W-sdr_pkg::DATA_W+1){1'b0}},
                {(sdr_pkg::DATA_W-1){1'b1}}})) begin
            sat_word = {1'b0, {(sdr_pkg::DATA_W-1){1'b1}}};
        end else if (s < $signed({{(sdr_pkg::ACC_W-sdr_pkg::DATA_W+1){1'b1}},
                {(sdr_pkg::DATA_W-1){1'b0}}})) begin
            sat_word = {1'b1, {(sdr_pkg::DATA_W-1){1'b0}}};
        end else begin
            sat_word = s[sdr_pkg::DATA_W-1:0];
        end
    endfunction : sat_word

    // Signed word to offset-binary DAC code
    function automatic logic [sdr_pkg::DAC_W-1:0] to_dac(input word_type w);
        to_dac = {~w[sdr_pkg::DATA_W-1], w[sdr_pkg::DATA_W-2 -: sdr_pkg::DAC_W-1]};
    endfunction : to_dac

    tune_if tif ();

    assign tif.n_int = tune_int;
    assign tif.n_frac = tune_frac;
    assign tif.fb_tick = pll_fb_tick;
    assign tif.lo_div = tune_lo_div;

    mash_modulator u_mash (
        .clk(clk),
        .rst(rst),
        .tif(tif)
    );

    lo_divider u_lo (
        .clk(clk),
        .rst(rst),
        .tif(tif)
    );

    always_comb begin
        st_d = st_q;
        st_d.start = 1'b0;
        st_d.dstb = 1'b0;
        prod = '0;
        sum = '0;

        // Conversion pacing
        if (st_q.adc_cnt == sdr_pkg::ADC_CNT_W'(sdr_pkg::ADC_PERIOD_CYC - 1)) begin
            st_d.adc_cnt = '0;
            st_d.start = 1'b1;
        end else begin
            st_d.adc_cnt = st_q.adc_cnt + sdr_pkg::ADC_CNT_W'(1);
        end

        // Coefficient banks are writable at any time
        if (coef_we) begin
            if (coef_bank == sdr_pkg::COEF_HILBERT) begin
                st_d.hc[coef_addr] = coef_data;
            end else begin
                st_d.lc[coef_addr] = coef_data;
            end
        end

        // Results alternate I then Q; mux flips after each
        if (adc_done) begin
            st_d.chan = ~st_q.chan;
            if (!st_q.chan) begin
                st_d.idly = {st_q.idly[sdr_pkg::DLY_LEN-2:0], to_word(adc_data)};
            end else begin
                st_d.qh = {st_q.qh[sdr_pkg::TAPS-2:0], to_word(adc_data)};
            end
        end

        case (st_q.st)
            sdr_pkg::ST_IDLE: begin
                // A Q result closes the pair; sideband is frozen for it
                if (adc_done && st_q.chan) begin
                    st_d.st = sdr_pkg::ST_HIL;
                    st_d.tap = '0;
                    st_d.acc = '0;
                    st_d.sb = sideband_add;
                end
            end
            sdr_pkg::ST_HIL: begin
                prod = $signed(st_q.hc[st_q.tap]) * $signed(st_q.qh[st_q.tap]);
                st_d.acc = st_q.acc + prod;
                st_d.tap = st_q.tap + sdr_pkg::TAP_W'(1);
                if (st_q.tap == sdr_pkg::LAST_TAP) begin
                    st_d.st = sdr_pkg::ST_COMB;
                    st_d.hil = sat_word(st_q.acc + prod);
                end
            end
            sdr_pkg::ST_COMB: begin
                // Oldest I sample lines up with the Hilbert group delay
                if (st_q.sb) begin
                    sum = st_q.idly[sdr_pkg::DLY_LEN-1] + st_q.hil;
                end else begin
                    sum = st_q.idly[sdr_pkg::DLY_LEN-1] - st_q.hil;
                end
                st_d.sh = {st_q.sh[sdr_pkg::TAPS-2:0], sum};
                st_d.tap = '0;
                st_d.acc = '0;
                st_d.st = sdr_pkg::ST_LPF;
            end
            sdr_pkg::ST_LPF: begin
                prod = $signed(st_q.lc[st_q.tap]) * $signed(st_q.sh[st_q.tap]);
                st_d.acc = st_q.acc + prod;
                st_d.tap = st_q.tap + sdr_pkg::TAP_W'(1);
                if (st_q.tap == sdr_pkg::LAST_TAP) begin
                    st_d.st = sdr_pkg::ST_OUT;
                end
            end
            sdr_pkg::ST_OUT: begin
                st_d.dac = to_dac(sat_word(st_q.acc));
                st_d.dstb = 1'b1;
                st_d.st = sdr_pkg::ST_IDLE;
            end
            default: begin
                st_d.st = sdr_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Straight from flip-flops here or inside the submodules
    assign pll_div_q = tif.div_value;
    assign lo_i_q = tif.lo_i;
    assign lo_q_q = tif.lo_q;
    assign adc_start_q = st_q.start;
    assign adc_chan_q = st_q.chan;
    assign dac_q = st_q.dac;
    assign dac_strobe_q = st_q.dstb;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_ADC_PERIOD: assert property (adc_start_q |-> ##[ADC_GAP:ADC_GAP] adc_start_q)
        else $error("conversion start spacing wrong");
    AST_ADC_QUIET: assert property (adc_start_q |=> !adc_start_q [*8])
        else $error("conversion start repeated too soon");
    AST_MUX_TOGGLE: assert property (adc_done |=> adc_chan_q != $past(adc_chan_q))
        else $error("input mux did not alternate");
    AST_I_TO_DELAY: assert property (adc_done && !adc_chan_q
        |=> st_q.idly[0] == to_word($past(adc_data)))
        else $error("I sample not pushed into delay line");
    AST_Q_STARTS_HIL: assert property (adc_done && adc_chan_q && st_q.st == sdr_pkg::ST_IDLE
        |=> st_q.st == sdr_pkg::ST_HIL && st_q.qh[0] == to_word($past(adc_data)))
        else $error("Q sample did not start the Hilbert pass");
    AST_HIL_TAPS: assert property (st_q.st == sdr_pkg::ST_HIL && st_q.tap == '0
        |-> ##FIR_LEN st_q.st == sdr_pkg::ST_COMB)
        else $error("Hilbert pass not exactly 64 taps");
    AST_LPF_TAPS: assert property (st_q.st == sdr_pkg::ST_COMB
        |=> (st_q.st == sdr_pkg::ST_LPF) ##FIR_LEN (st_q.st == sdr_pkg::ST_OUT))
        else $error("low-pass pass not exactly 64 taps");
    AST_SIDEBAND: assert property (st_q.st == sdr_pkg::ST_COMB
        |=> st_q.sh[0] == ($past(st_q.sb)
            ? $past(st_q.idly[sdr_pkg::DLY_LEN-1]) + $past(st_q.hil)
            : $past(st_q.idly[sdr_pkg::DLY_LEN-1]) - $past(st_q.hil)))
        else $error("combiner used wrong sideband sum");
    AST_SB_LATCH: assert property ($rose(st_q.st == sdr_pkg::ST_HIL)
        |-> st_q.sb == $past(sideband_add))
        else $error("sideband not captured at pair start");
    AST_DAC_OUT: assert property (st_q.st == sdr_pkg::ST_OUT
        |=> dac_strobe_q && dac_q == to_dac(sat_word($past(st_q.acc))))
        else $error("DAC not written with low-pass result");
    AST_DAC_PULSE: assert property (dac_strobe_q |=> !dac_strobe_q)
        else $error("DAC strobe longer than one cycle");

    // Converter pacing and input mux stay put between events
    AST_START_CNT: assert property (adc_start_q
        |-> st_q.adc_cnt == '0)
        else $error("conversion start off the pacing wrap");
    AST_CHAN_HOLD: assert property (!adc_done
        |=> $stable(adc_chan_q))
        else $error("input mux moved without a result");

    // Sample stores only move on their own channel's result
    AST_IDLY_HOLD: assert property (!(adc_done && !adc_chan_q)
        |=> $stable(st_q.idly))
        else $error("I delay line moved without an I result");
    AST_QH_HOLD: assert property (!(adc_done && adc_chan_q)
        |=> $stable(st_q.qh))
        else $error("Q history moved without a Q result");
    AST_IDLE_WAIT: assert property (st_q.st == sdr_pkg::ST_IDLE
        && !(adc_done && adc_chan_q) |=> st_q.st == sdr_pkg::ST_IDLE)
        else $error("filter pass started without a Q result");

    // Coefficient writes land in the addressed tap next cycle
    AST_COEF_HIL: assert property (coef_we && coef_bank == sdr_pkg::COEF_HILBERT
        |=> st_q.hc[$past(coef_addr)] == $past(coef_data))
        else $error("Hilbert coefficient write lost");
    AST_COEF_LPF: assert property (coef_we && coef_bank == sdr_pkg::COEF_LOWPASS
        |=> st_q.lc[$past(coef_addr)] == $past(coef_data))
        else $error("low-pass coefficient write lost");

    // Each pass opens clean and walks the taps one per cycle
    AST_HIL_CLEAR: assert property ($rose(st_q.st == sdr_pkg::ST_HIL)
        |-> st_q.tap == '0 && st_q.acc == '0)
        else $error("Hilbert pass did not start from tap zero");
    AST_HIL_STEP: assert property (st_q.st == sdr_pkg::ST_HIL
        |=> st_q.tap == $past(st_q.tap) + sdr_pkg::TAP_W'(1))
        else $error("Hilbert tap index skipped");
    AST_HIL_STAY: assert property (st_q.st == sdr_pkg::ST_HIL
        && st_q.tap != sdr_pkg::LAST_TAP |=> st_q.st == sdr_pkg::ST_HIL)
        else $error("Hilbert pass left before its last tap");
    AST_LPF_CLEAR: assert property ($rose(st_q.st == sdr_pkg::ST_LPF)
        |-> st_q.tap == '0 && st_q.acc == '0)
        else $error("low-pass pass did not start from tap zero");
    AST_LPF_STEP: assert property (st_q.st == sdr_pkg::ST_LPF
        |=> st_q.tap == $past(st_q.tap) + sdr_pkg::TAP_W'(1))
        else $error("low-pass tap index skipped");

    // A zero tap leaves the running sum untouched
    AST_HIL_ZERO: assert property (st_q.st == sdr_pkg::ST_HIL
        && st_q.hc[st_q.tap] == '0 |=> $stable(st_q.acc))
        else $error("Hilbert sum moved on a zero tap");
    AST_LPF_ZERO: assert property (st_q.st == sdr_pkg::ST_LPF
        && st_q.lc[st_q.tap] == '0 |=> $stable(st_q.acc))
        else $error("low-pass sum moved on a zero tap");

    // Results only change at their own step
    AST_SB_HOLD: assert property (st_q.st != sdr_pkg::ST_IDLE
        |=> $stable(st_q.sb))
        else $error("sideband changed inside a pass");
    AST_HIL_HOLD: assert property (st_q.st != sdr_pkg::ST_HIL
        |=> $stable(st_q.hil))
        else $error("Hilbert result changed outside its pass");
    AST_SH_HOLD: assert property (st_q.st != sdr_pkg::ST_COMB
        |=> $stable(st_q.sh))
        else $error("low-pass history moved outside the combiner");

    // Converter feed
    AST_DAC_HOLD: assert property (st_q.st != sdr_pkg::ST_OUT
        |=> $stable(dac_q))
        else $error("DAC code changed without a write");
    AST_DAC_SRC: assert property (dac_strobe_q
        |-> $past(st_q.st) == sdr_pkg::ST_OUT)
        else $error("DAC strobe without an output step");
    AST_OUT_ONE: assert property (st_q.st == sdr_pkg::ST_OUT
        |=> st_q.st == sdr_pkg::ST_IDLE)
        else $error("output step not followed by idle");

    COV_DAC_WRITE: cover property (dac_strobe_q);
    COV_SB_SWITCH: cover property (st_q.st == sdr_pkg::ST_COMB && st_q.sb
        ##[1:1000] st_q.st == sdr_pkg::ST_COMB && !st_q.sb);
    COV_PAIR: cover property (adc_done && !adc_chan_q ##[1:1000] adc_done && adc_chan_q);
endmodule : sdr_core
`default_nettype wire

// file: verif/baseband_adc_model.sv
/*
 * Behavioural shared converter with its I/Q input multiplexer.
 * Assumes one start pulse per conversion and clk shared with the core.
 */
`timescale 1ns/100ps
`default_nettype none
module baseband_adc_model #(
    parameter int CONV_CYC = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Converter control from the core
    input wire logic adc_start_q,
    input wire logic adc_chan_q,
    // Analog levels set by the bench
    input wire logic [13:0] i_level,
    input wire logic [13:0] q_level,
    // Result to the core
    output logic adc_done,
    output logic [13:0] adc_data
);
    int cnt = 0;

    // Data outside a result toggles so a stale value never looks valid
    always @(negedge clk) begin
        adc_done <= 1'b0;
        adc_data <= ~adc_data;
        if (rst) begin
            cnt <= 0;
            adc_data <= 14'h0000;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                adc_done <= 1'b1;
                adc_data <= adc_chan_q ? q_level : i_level;
            end
        end else if (adc_start_q) begin
            cnt <= CONV_CYC;
        end
    end
endmodule : baseband_adc_model
`default_nettype wire

// file: verif/test_sdr_core.sv
/*
 * Self-checking bench for sdr_core, one task per scenario.
 * Assumes baseband_adc_model answers every converter start.
 */
`timescale 1ns/100ps
`default_nettype none
module test_sdr_core;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] tune_int = 8'h40;
    logic [13:0] tune_frac = 14'h0000;
    logic [7:0] tune_lo_div = 8'h03;
    logic pll_fb_tick = 1'b0;
    logic [7:0] pll_div_q;
    logic lo_i_q;
    logic lo_q_q;
    logic adc_start_q;
    logic adc_chan_q;
    logic adc_done;
    logic [13:0] adc_data;
    logic coef_we = 1'b0;
    logic coef_bank = 1'b0;
    logic [5:0] coef_addr = 6'h00;
    logic [23:0] coef_data = 24'h00_0000;
    logic sideband_add = 1'b1;
    logic [7:0] dac_q;
    logic dac_strobe_q;
    logic [13:0] i_level = 14'h0000;
    logic [13:0] q_level = 14'h0000;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    // Audio settling needs about 36 sample pairs of 1246 cycles
    localparam int LIMIT = 60000;

    sdr_core sdr_core_i (
        .clk(clk), .rst(rst), .tune_int(tune_int), .tune_frac(tune_frac),
        .tune_lo_div(tune_lo_div), .pll_fb_tick(pll_fb_tick), .pll_div_q(pll_div_q),
        .lo_i_q(lo_i_q), .lo_q_q(lo_q_q), .adc_start_q(adc_start_q),
        .adc_chan_q(adc_chan_q), .adc_done(adc_done), .adc_data(adc_data),
        .coef_we(coef_we), .coef_bank(coef_bank), .coef_addr(coef_addr),
        .coef_data(coef_data), .sideband_add(sideband_add), .dac_q(dac_q),
        .dac_strobe_q(dac_strobe_q)
    );

    baseband_adc_model baseband_adc_model_i (
        .clk(clk), .rst(rst), .adc_start_q(adc_start_q), .adc_chan_q(adc_chan_q),
        .i_level(i_level), .q_level(q_level), .adc_done(adc_done), .adc_data(adc_data)
    );

    initial begin
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            $display("ERROR run length expected below %0d seen %0d", LIMIT, cycles);
            results();
        end
    end

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Look just after the rising edge, once its updates have landed
    task obs;
        @(posedge clk);
        #1;
    endtask : obs

    task t_reset;
        check("outputs in reset", 32'h0,
            {pll_div_q, lo_i_q, lo_q_q, adc_start_q, adc_chan_q, dac_q, dac_strobe_q});
        $display("test reset done");
    endtask : t_reset

    task t_lo;
        logic [25:0] iv;
        logic [25:0] qv;
        int a;
        a = 0;
        repeat (8) obs();
        for (int k = 0; k < 26; k++) begin
            obs();
            iv[k] = lo_i_q;
            qv[k] = lo_q_q;
        end
        for (int k = 13; k >= 1; k--) begin
            if (iv[k] && !iv[k-1]) a = k;
        end
        check("lo_q rise", 32'h1, qv[a+3] & !qv[a+2]);
        check("lo_i fall", 32'h1, !iv[a+6] & iv[a+5]);
        check("lo_i period", 32'h1, iv[a+12] & !iv[a+11]);
        $display("test lo_divider done");
    endtask : t_lo

    task tick(output logic [7:0] v);
        @(negedge clk) pll_fb_tick = 1'b1;
        @(negedge clk) pll_fb_tick = 1'b0;
        repeat (2) @(negedge clk);
        v = pll_div_q;
    endtask : tick

    task t_mash;
        logic [7:0] v;
        int sum;
        sum = 0;
        repeat (4) begin
            tick(v);
            check("pll_div integer", 32'h40, v);
        end
        @(negedge clk) tune_int = 8'h50;
        repeat (10) @(negedge clk);
        check("pll_div held", 32'h40, pll_div_q);
        tune_frac = 14'h2000;
        repeat (64) begin
            tick(v);
            sum += v;
            check("pll_div range", 32'h1, v >= 8'h4f && v <= 8'h52);
        end
        // Half step: mean N + 0.5, end effects bounded by the second stage
        check("pll_div mean", 32'h1, sum >= 5150 && sum <= 5154);
        $display("test modulator done");
    endtask : t_mash

    task t_adc;
        int n;
        logic c;
        n = 1;
        for (int k = 0; k < 1300 && adc_start_q !== 1'b1; k++) obs();
        obs();
        while (adc_start_q !== 1'b1 && n < 1300) begin
            obs();
            n++;
        end
        check("adc start period", sdr_pkg::ADC_PERIOD_CYC, n);
        c = adc_chan_q;
        for (int k = 0; k < 700 && adc_done !== 1'b1; k++) begin
            c = adc_chan_q;
            obs();
        end
        check("adc channel flip", c ? 32'h0 : 32'h1, adc_chan_q);
        $display("test converter done");
    endtask : t_adc

    task coef(input logic bank, input logic [23:0] d);
        @(negedge clk) begin
            coef_we = 1'b1;
            coef_bank = bank;
            coef_addr = 6'h00;
            coef_data = d;
        end
        @(negedge clk) coef_we = 1'b0;
    endtask : coef

    task wait_q(output int lat);
        logic c;
        c = 1'b0;
        for (int k = 0; k < 1400 && !(adc_done === 1'b1 && c === 1'b1); k++) begin
            c = adc_chan_q;
            obs();
        end
        lat = 0;
        while (dac_strobe_q !== 1'b1 && lat < 400) begin
            obs();
            lat++;
        end
    endtask : wait_q

    task t_audio;
        int lat;
        coef(sdr_pkg::COEF_HILBERT, 24'h40_0000);
        coef(sdr_pkg::COEF_LOWPASS, 24'h40_0000);
        @(negedge clk) begin
            i_level = 14'h0800;
            q_level = 14'h0400;
            sideband_add = 1'b1;
        end
        // Enough pairs to fill the I delay line with the new level
        repeat (34) wait_q(lat);
        // Counted from the cycle after the pair completes
        check("dac latency", 32'd130, lat);
        check("dac sum", 32'h94, dac_q);
        @(negedge clk) sideband_add = 1'b0;
        wait_q(lat);
        check("dac difference", 32'h8c, dac_q);
        $display("test audio path done");
    endtask : t_audio

    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    initial begin
        repeat (5) @(negedge clk);
        t_reset();
        rst = 1'b0;
        t_lo();
        t_mash();
        t_adc();
        t_audio();
        results();
    end
endmodule : test_sdr_core
`default_nettype wire
